// *** err_report_pkg.sv ***
// package: constants and types for the counter unit error reporter
package err_report_pkg;

    // ----------------------------------------
    // host word offsets
    // ----------------------------------------
    localparam logic [7:0] error_code_first_word_off = 8'h11;
    localparam logic [7:0] error_code_second_word_off = 8'h12;
    localparam logic [7:0] global_error_status_word_off = 8'h13;
    localparam int global_error_bit = 0;

    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int log_depth = 30;
    localparam logic [4:0] log_last = 5'h1d;
    localparam logic [15:0] word_reset = 16'h0000;
    localparam int category_count = 6;

    // ----------------------------------------
    // system refresh timing
    // ----------------------------------------
    localparam int refresh_limit_s = 11;
    localparam int clock_hz = 40000000;
    localparam longint refresh_limit_cycles = longint'(refresh_limit_s) * longint'(clock_hz);

    // ----------------------------------------
    // error categories, code word and indicator types
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        cat_config_memory,
        cat_host_write,
        cat_over_under,
        cat_preset,
        cat_irq_queue_full,
        cat_system
    } category_e;

    typedef struct packed
    {
        logic [15:0] first;
        logic [15:0] second;
    } error_code_s;

    typedef struct packed
    {
        logic run;
        logic cond_err;
        logic host_err;
    } indicators_s;

endpackage : err_report_pkg

// *** counter_unit_error_reporter.sv ***
// module: error indicators, code words and error history log
`timescale 1ns/1ps
module counter_unit_error_reporter
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic setup_fault_in,
    input wire logic classification_fault_in,
    input wire logic watchdog_expired_in,
    input wire logic system_error_in,
    input wire logic error_valid_in,
    input wire err_report_pkg::category_e error_category_in,
    input wire err_report_pkg::error_code_s error_code_in,
    input wire logic error_clear_in,
    input wire logic read_next_error_in,
    input wire logic [7:0] host_addr_in,
    output logic [15:0] host_rdata_out,
    output err_report_pkg::indicators_s indicators_out,
    output err_report_pkg::error_code_s code_words_out,
    output logic global_error_out,
    output logic counting_stopped_out
);

    // ----------------------------------------
    // read-next pin synchroniser and rising-edge detect
    // ----------------------------------------
    logic [1:0] rne_sync;
    logic rne_prev;
    logic rne_rise;

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rne_sync <= 2'b00;
            rne_prev <= 1'b0;
        end
        else
        begin
            rne_sync <= {rne_sync[0], read_next_error_in};
            rne_prev <= rne_sync[1];
        end
    end

    assign rne_rise = rne_sync[1] & ~rne_prev;

    // ----------------------------------------
    // history log
    // ----------------------------------------
    err_report_pkg::error_code_s log_mem [err_report_pkg::log_depth];
    logic [4:0] log_count;
    logic [4:0] log_head;
    logic [4:0] read_idx;
    logic [4:0] next_head;
    logic [4:0] read_pos;
    logic [5:0] pos_sum;

    assign next_head = (log_head == err_report_pkg::log_last) ? 5'h00 : log_head + 5'h01;
    assign pos_sum = {1'b0, log_head} + {1'b0, read_idx};
    assign read_pos = (pos_sum >= 6'(err_report_pkg::log_depth)) ?
        5'(pos_sum - 6'(err_report_pkg::log_depth)) : pos_sum[4:0];

    always_ff @(posedge clock_in)
    begin
        if (error_valid_in)
        begin
            log_mem[(log_count == 5'(err_report_pkg::log_depth)) ? log_head :
                5'((32'(log_head) + 32'(log_count)) % err_report_pkg::log_depth)]
                <= error_code_in;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            log_count <= 5'h00;
            log_head <= 5'h00;
        end
        else if (error_valid_in)
        begin
            if (log_count == 5'(err_report_pkg::log_depth))
            begin
                log_head <= next_head;
            end
            else
            begin
                log_count <= log_count + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // code words and read-next scrolling
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            code_words_out <= '0;
            read_idx <= 5'h00;
        end
        else if (error_valid_in)
        begin
            code_words_out <= error_code_in;
            read_idx <= 5'h00;
        end
        else if (error_clear_in)
        begin
            code_words_out <= '0;
            read_idx <= 5'h00;
        end
        else if (rne_rise)
        begin
            if (read_idx < log_count)
            begin
                code_words_out <= log_mem[read_pos];
                read_idx <= read_idx + 5'h01;
            end
            else
            begin
                code_words_out <= '0;
                read_idx <= 5'h00;
            end
        end
    end

    // ----------------------------------------
    // global flag, counting stop
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            global_error_out <= 1'b0;
            counting_stopped_out <= 1'b0;
        end
        else
        begin
            if (error_valid_in)
            begin
                global_error_out <= 1'b1;
            end
            else if (error_clear_in)
            begin
                global_error_out <= 1'b0;
            end
            if (error_valid_in && error_category_in == err_report_pkg::cat_config_memory)
            begin
                counting_stopped_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // indicators, by priority
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            indicators_out <= '{run: 1'b0, cond_err: 1'b0, host_err: 1'b0};
        end
        else if (watchdog_expired_in)
        begin
            indicators_out <= '{run: 1'b0, cond_err: 1'b0, host_err: 1'b0};
        end
        else if (classification_fault_in)
        begin
            indicators_out <= '{run: 1'b0, cond_err: 1'b1, host_err: 1'b1};
        end
        else if (setup_fault_in)
        begin
            indicators_out <= '{run: 1'b0, cond_err: 1'b0, host_err: 1'b1};
        end
        else if (counting_stopped_out ||
            (error_valid_in && error_category_in == err_report_pkg::cat_config_memory))
        begin
            indicators_out <= '{run: 1'b0, cond_err: 1'b1, host_err: 1'b0};
        end
        else if (system_error_in)
        begin
            indicators_out <= '{run: 1'b1, cond_err: 1'b0, host_err: 1'b1};
        end
        else if (error_valid_in || (global_error_out && !error_clear_in))
        begin
            indicators_out <= '{run: 1'b1, cond_err: 1'b1, host_err: 1'b0};
        end
        else
        begin
            indicators_out <= '{run: 1'b1, cond_err: 1'b0, host_err: 1'b0};
        end
    end

    // ----------------------------------------
    // host word read port
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            host_rdata_out <= err_report_pkg::word_reset;
        end
        else
        begin
            case (host_addr_in)
                err_report_pkg::error_code_first_word_off:
                    host_rdata_out <= code_words_out.first;
                err_report_pkg::error_code_second_word_off:
                    host_rdata_out <= code_words_out.second;
                err_report_pkg::global_error_status_word_off:
                    host_rdata_out <= {15'h0000, global_error_out};
                default:
                    host_rdata_out <= err_report_pkg::word_reset;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_err;
        error_valid_in;
    endsequence

    AST_ERR_LOADS_WORDS: assert property (@(posedge clock_in) disable iff (!nrst_in)
        s_err |=> code_words_out == $past(error_code_in))
        else $error("code words not loaded on error");

    AST_ERR_SETS_FLAG: assert property (@(posedge clock_in) disable iff (!nrst_in)
        s_err |=> global_error_out)
        else $error("global flag not set on error");

    AST_CLEAR_ZEROES: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (error_clear_in && !error_valid_in) |=> (code_words_out == '0 && !global_error_out))
        else $error("clear did not zero words");

    AST_WDT_DARK: assert property (@(posedge clock_in) disable iff (!nrst_in)
        watchdog_expired_in |=> indicators_out == 3'b000)
        else $error("indicators not off on watchdog");

    AST_CLASS_IND: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (!watchdog_expired_in && classification_fault_in) |=> indicators_out == 3'b011)
        else $error("classification indicators wrong");

    AST_SETUP_IND: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (!watchdog_expired_in && !classification_fault_in && setup_fault_in)
        |=> indicators_out == 3'b001)
        else $error("setup indicators wrong");

    AST_LOG_BOUND: assert property (@(posedge clock_in) disable iff (!nrst_in)
        log_count <= 5'(err_report_pkg::log_depth))
        else $error("log count above depth");

    AST_FULL_DROPS: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (s_err and log_count == 5'(err_report_pkg::log_depth)) |=> log_head != $past(log_head))
        else $error("oldest entry not dropped");

    AST_END_ZERO: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (rne_rise && !error_valid_in && !error_clear_in && read_idx >= log_count)
        |=> (code_words_out == '0 && read_idx == 5'h00))
        else $error("read past end not zero");

    AST_CFG_STOPS: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (s_err and error_category_in == err_report_pkg::cat_config_memory)
        |=> counting_stopped_out ##1 indicators_out.run == 1'b0)
        else $error("counting not stopped on config fault");

endmodule : counter_unit_error_reporter

// *** err_host_model.sv ***
// host processor model: read-next bit and cyclic refresh watchdog
`timescale 1ns/1ps
module err_host_model
#(
    parameter int refresh_limit = 20
)
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic step_in,
    input wire logic refresh_off_in,
    output logic read_next_out,
    output logic system_error_out
);
    logic [2:0] hold;
    int unsigned idle;

    // ----------------------------------------
    // read-next bit, held high for four cycles
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
            hold <= 3'h0;
        else if (step_in)
            hold <= 3'h4;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end
    assign read_next_out = (hold != 3'h0);

    // ----------------------------------------
    // missing refresh raises a system error
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
            idle <= 0;
        else if (!refresh_off_in)
            idle <= 0;
        else if (idle < refresh_limit)
            idle <= idle + 1;
    end
    assign system_error_out = (idle >= refresh_limit);
endmodule : err_host_model

// *** counter_unit_error_reporter_bench.sv ***
// testbench for the counter unit error reporter
`timescale 1ns/1ps
module counter_unit_error_reporter_bench;
    localparam int limit = 20;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [2:0] faults = 3'b000;
    logic sys_err;
    logic error_valid_in = 1'b0;
    err_report_pkg::category_e error_category_in = err_report_pkg::cat_host_write;
    err_report_pkg::error_code_s error_code_in = '0;
    logic error_clear_in = 1'b0;
    logic read_next;
    logic step = 1'b0;
    logic refresh_off = 1'b0;
    logic [7:0] host_addr_in = 8'h00;
    logic [15:0] host_rdata_out;
    err_report_pkg::indicators_s indicators_out;
    err_report_pkg::error_code_s code_words_out;
    logic global_error_out;
    logic counting_stopped_out;
    int err_count = 0;
    int checks = 0;

    always #12.5 clock_in = ~clock_in;

    counter_unit_error_reporter uut
    (
        .clock_in(clock_in), .nrst_in(nrst_in), .setup_fault_in(faults[0]),
        .classification_fault_in(faults[1]), .watchdog_expired_in(faults[2]),
        .system_error_in(sys_err), .error_valid_in(error_valid_in),
        .error_category_in(error_category_in), .error_code_in(error_code_in),
        .error_clear_in(error_clear_in), .read_next_error_in(read_next),
        .host_addr_in(host_addr_in), .host_rdata_out(host_rdata_out),
        .indicators_out(indicators_out), .code_words_out(code_words_out),
        .global_error_out(global_error_out), .counting_stopped_out(counting_stopped_out)
    );

    err_host_model #(.refresh_limit(limit)) host
    (
        .clock_in(clock_in), .nrst_in(nrst_in), .step_in(step),
        .refresh_off_in(refresh_off), .read_next_out(read_next),
        .system_error_out(sys_err)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] code_of(input logic [7:0] k);
        return {8'h03, k, 8'h10, k};
    endfunction : code_of

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic raise(input logic [7:0] k, input err_report_pkg::category_e cat);
        @(posedge clock_in);
        error_valid_in <= 1'b1;
        error_category_in <= cat;
        error_code_in <= code_of(k);
        @(posedge clock_in);
        error_valid_in <= 1'b0;
        #1;
    endtask : raise

    task automatic clear_err();
        @(posedge clock_in);
        error_clear_in <= 1'b1;
        @(posedge clock_in);
        error_clear_in <= 1'b0;
        #1;
    endtask : clear_err

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        host_addr_in <= a;
        @(posedge clock_in);
        #1;
        chk("host word", {16'h0000, host_rdata_out}, {16'h0000, exp});
    endtask : rd

    task automatic nxt(input logic [31:0] exp);
        @(posedge clock_in);
        step <= 1'b1;
        @(posedge clock_in);
        step <= 1'b0;
        repeat (6) @(posedge clock_in);
        #1;
        chk("code words", code_words_out, exp);
    endtask : nxt

    task automatic conclude();
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        chk("indicators", indicators_out, 3'b100);
        for (int k = 1; k <= 3; k++)
            raise(8'(k), err_report_pkg::category_e'(k));
        chk("code words", code_words_out, code_of(8'h03));
        chk("global", global_error_out, 1'b1);
        chk("indicators", indicators_out, 3'b110);
        rd(8'h11, 16'h0303);
        rd(8'h12, 16'h1003);
        rd(8'h13, 16'h0001);
        rd(8'h20, 16'h0000);
        nxt(code_of(8'h01));
        nxt(code_of(8'h02));
        nxt(code_of(8'h03));
        nxt(32'h0000_0000);
        nxt(code_of(8'h01));
        clear_err();
        chk("code words", code_words_out, 32'h0000_0000);
        chk("global", global_error_out, 1'b0);
        chk("indicators", indicators_out, 3'b100);
        for (int k = 4; k <= 34; k++)
            raise(8'(k), err_report_pkg::category_e'(1 + k % 5));
        chk("code words", code_words_out, code_of(8'h22));
        nxt(code_of(8'h05));
        clear_err();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock_in);
            faults <= 3'b001 << i;
            repeat (3) @(posedge clock_in);
            #1;
            chk("indicators", indicators_out, i == 0 ? 3'b001 : i == 1 ? 3'b011 : 3'b000);
        end
        @(posedge clock_in);
        faults <= 3'b000;
        refresh_off <= 1'b1;
        repeat (limit + 4) @(posedge clock_in);
        #1;
        chk("indicators", indicators_out, 3'b101);
        @(posedge clock_in);
        refresh_off <= 1'b0;
        repeat (2) @(posedge clock_in);
        raise(8'h28, err_report_pkg::cat_config_memory);
        repeat (2) @(posedge clock_in);
        #1;
        chk("indicators", indicators_out, 3'b010);
        chk("code words", code_words_out, code_of(8'h28));
        chk("stopped", counting_stopped_out, 1'b1);
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        conclude();
    end
endmodule : counter_unit_error_reporter_bench
